// file: axis_threshold.sv
`timescale 1ns/100ps

// One axis against one threshold, either absolute or signed
module axis_threshold (
  input  wire logic signed [7:0] sample_i,
  input  wire logic        [7:0] threshold_i,
  input  wire logic              signed_mode_i,
  input  wire logic              negative_i,
  output logic                   meets_o
);

  wire [7:0] mag      = sample_i[7] ? 8'(-sample_i) : sample_i;
  // Absolute mode ignores threshold bit 7
  wire       abs_ge   = (mag >= {1'b0, threshold_i[6:0]});
  wire       sgn_ge   = (sample_i >= $signed(threshold_i));
  wire       above    = signed_mode_i ? sgn_ge : abs_ge;

  // Negative polarity looks for the sample below the threshold
  assign meets_o = negative_i ? ~above : above;

endmodule

// file: motion_checker.sv
`timescale 1ns/100ps

// Port-level checks on the register bus and the sample path
module motion_checker
  import motion_pkg::*;
#(
  parameter int unsigned HALF_MS_CYCLES = 4
) (
  input  wire logic     clk_i,
  input  wire logic     resetn_i,
  input  wire logic     avs_read_i,
  input  wire logic     avs_write_i,
  input  wire logic     avs_waitrequest_o,
  input  wire raw_vec_t raw_sample_i,
  input  wire logic     sample_valid_i,
  input  wire out_vec_t accel_o,
  input  wire logic     filter_bw_sel_o,
  input  wire logic     drive_strong_o,
  input  wire logic     level_event_o,
  input  wire logic     pulse_event_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // A fresh request is answered after exactly one wait cycle
  wait_answer_a: assert property ((avs_read_i || avs_write_i) &&
    !$past(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
    else $error("request not answered after one wait cycle");
  wait_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  level_pulse_a: assert property (level_event_o |-> $past(sample_valid_i))
    else $error("level event without a sample");
  pulse_once_a: assert property (pulse_event_o |=> !pulse_event_o)
    else $error("pulse event longer than one cycle");
  accel_hold_a: assert property (!sample_valid_i |=> $stable(accel_o))
    else $error("acceleration moved without a sample");
  zero_map_a: assert property (
    sample_valid_i && raw_sample_i.z == 10'h000 |=> accel_o.z == 8'h00)
    else $error("zero acceleration not encoded as zero");
  pos_sat_a: assert property (
    sample_valid_i && raw_sample_i.x == 10'h1ff |=> accel_o.x == 8'h7f)
    else $error("positive full scale not saturated");
  neg_sat_a: assert property (
    sample_valid_i && raw_sample_i.y == 10'h200 |=> accel_o.y == 8'h80)
    else $error("negative full scale not saturated");
  drive_hold_a: assert property (
    !avs_write_i && !$past(avs_write_i) |=> $stable(drive_strong_o))
    else $error("drive select changed without a write");
  bw_hold_a: assert property (
    !avs_write_i && !$past(avs_write_i) |=> $stable(filter_bw_sel_o))
    else $error("bandwidth select changed without a write");
endmodule

bind motion_detect_config motion_checker #(
  .HALF_MS_CYCLES(HALF_MS_CYCLES)
) u_motion_checker (.clk_i, .resetn_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .raw_sample_i, .sample_valid_i, .accel_o,
  .filter_bw_sel_o, .drive_strong_o, .level_event_o, .pulse_event_o);

// file: motion_detect_config.sv
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps
`include "motion_params.svh"

module motion_detect_config
  import motion_pkg::*;
#(
  parameter int unsigned HALF_MS_CYCLES = `HALF_MS_CYCLES
) (
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  input  wire logic [`ADDR_W-1:0]  avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  input  wire raw_vec_t            raw_sample_i,
  input  wire logic                sample_valid_i,
  output out_vec_t                 accel_o,
  output logic                     filter_bw_sel_o,
  output logic                     drive_strong_o,
  output logic                     level_event_o,
  output logic                     pulse_event_o,
  output logic                     irq_o
);

  // Reset release through two flops
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Configuration and interrupt registers
  logic [7:0] mode_q;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] lthr_q;
  logic [7:0] pthr_q;
  logic [7:0] pdur_q;
  logic [7:0] lat_q;
  logic [7:0] win_q;
  logic [7:0] status_q;
  logic [7:0] mask_q;
  logic       wait_q;
  logic [7:0] rdata;

  // Field decode
  wire [1:0] op_mode                 = mode_q[`MODE_LSB +: 2];
  wire [1:0] g_range                 = mode_q[`GLVL_LSB +: 2];
  wire       threshold_format_select = ctrl1_q[`C1_FMT_SEL];
  wire [2:0] axis_dis                = ctrl1_q[`C1_DIS_LSB +: 3];
  wire       level_polarity_select   = ctrl2_q[`C2_LVL_POL];
  wire       pulse_polarity_select   = ctrl2_q[`C2_PLS_POL];
  wire       level_on                = (op_mode == `MODE_LEVEL);
  wire       pulse_on                = (op_mode == `MODE_PULSE);

  // Avalon decode; wait one cycle so read data comes from a flop
  wire       req       = avs_read_i | avs_write_i;
  wire       accept    = req & ~wait_q;
  wire       wr_en     = avs_write_i & accept;
  wire [7:0] idx       = avs_address_i[`ADDR_W-1:2];
  wire [7:0] wdata     = avs_writedata_i[7:0];
  wire       hit_mode  = (idx == `IDX_MODE);
  wire       hit_ctrl1 = (idx == `IDX_CTRL1);
  wire       hit_ctrl2 = (idx == `IDX_CTRL2);
  wire       hit_lthr  = (idx == `IDX_LTHR);
  wire       hit_pthr  = (idx == `IDX_PTHR);
  wire       hit_pdur  = (idx == `IDX_PDUR);
  wire       hit_lat   = (idx == `IDX_LAT);
  wire       hit_win   = (idx == `IDX_WIN);
  wire       hit_stat  = (idx == `IDX_STATUS);
  wire       hit_mask  = (idx == `IDX_MASK);

  // Read mux; unmapped addresses read zero
  always_comb begin
    if (hit_mode) begin
      rdata = mode_q;
    end else if (hit_ctrl1) begin
      rdata = ctrl1_q;
    end else if (hit_ctrl2) begin
      rdata = ctrl2_q;
    end else if (hit_lthr) begin
      rdata = lthr_q;
    end else if (hit_pthr) begin
      rdata = pthr_q;
    end else if (hit_pdur) begin
      rdata = pdur_q;
    end else if (hit_lat) begin
      rdata = lat_q;
    end else if (hit_win) begin
      rdata = win_q;
    end else if (hit_stat) begin
      rdata = status_q;
    end else if (hit_mask) begin
      rdata = mask_q;
    end else begin
      rdata = 8'h00;
    end
  end

  // Bus handshake and read data
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wait_q         <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      if (accept) begin
        wait_q <= 1'b1;
      end else if (req) begin
        wait_q <= 1'b0;
      end
      if (req && wait_q) begin
        avs_readdata_o <= {24'h0, rdata};
      end
    end
  end
  assign avs_waitrequest_o = wait_q;

  // Writable registers; masks keep unused bits at zero
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q  <= `REG_RESET;
      ctrl1_q <= `REG_RESET;
      ctrl2_q <= `REG_RESET;
      lthr_q  <= `REG_RESET;
      pthr_q  <= `REG_RESET;
      pdur_q  <= `REG_RESET;
      lat_q   <= `REG_RESET;
      win_q   <= `REG_RESET;
      mask_q  <= `REG_RESET;
    end else if (wr_en) begin
      if (hit_mode)  mode_q  <= wdata & `MODE_MASK;
      if (hit_ctrl1) ctrl1_q <= wdata & `CTRL1_MASK;
      if (hit_ctrl2) ctrl2_q <= wdata & `CTRL2_MASK;
      if (hit_lthr)  lthr_q  <= wdata;
      if (hit_pthr)  pthr_q  <= wdata;
      if (hit_pdur)  pdur_q  <= wdata;
      if (hit_lat)   lat_q   <= wdata;
      if (hit_win)   win_q   <= wdata;
      if (hit_mask)  mask_q  <= wdata & `EV_MASK;
    end
  end

  // Range scaling with saturation into 8 bits
  function automatic out_axis_t scale_axis(raw_axis_t raw, logic [1:0] rng);
    raw_axis_t s;
    s = raw;
    if (rng == `GLVL_4G) begin
      s = raw >>> 1;
    end else if (rng == `GLVL_8G) begin
      s = raw >>> 2;
    end
    if (s > $signed(10'sd127)) begin
      return `SAT_POS;
    end else if (s < $signed(-10'sd128)) begin
      return `SAT_NEG;
    end
    return s[7:0];
  endfunction

  // Per-axis scaling and threshold comparison
  raw_axis_t raw_ax [3];
  out_axis_t scaled [3];
  logic [2:0] lvl_meet;
  logic [2:0] pls_meet;
  assign raw_ax[0] = raw_sample_i.x;
  assign raw_ax[1] = raw_sample_i.y;
  assign raw_ax[2] = raw_sample_i.z;

  for (genvar a = 0; a < 3; a++) begin : g_axis
    assign scaled[a] = scale_axis(raw_ax[a], g_range);
    // Level: format select picks absolute or signed
    axis_threshold u_lvl (
      .sample_i      (scaled[a]),
      .threshold_i   (lthr_q),
      .signed_mode_i (threshold_format_select),
      .negative_i    (level_polarity_select),
      .meets_o       (lvl_meet[a])
    );
    // Pulse: always absolute, top bit dropped
    axis_threshold u_pls (
      .sample_i      (scaled[a]),
      .threshold_i   ({1'b0, pthr_q[6:0]}),
      .signed_mode_i (1'b0),
      .negative_i    (pulse_polarity_select),
      .meets_o       (pls_meet[a])
    );
  end

  // Axis combination; disabled axes drop out of both forms
  wire [2:0] en       = ~axis_dis;
  wire       lvl_or   = |(lvl_meet & en);
  wire       lvl_and  = (|en) & (&(lvl_meet | axis_dis));
  wire       pls_or   = |(pls_meet & en);
  wire       pls_and  = (|en) & (&(pls_meet | axis_dis));
  wire       lvl_cond = level_polarity_select ? lvl_and : lvl_or;
  wire       pls_cond = pulse_polarity_select ? pls_and : pls_or;

  // Output samples and pulse condition held between samples
  logic pls_cond_q;
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      accel_o    <= '0;
      pls_cond_q <= 1'b0;
    end else if (sample_valid_i) begin
      accel_o    <= '{z: scaled[2], y: scaled[1], x: scaled[0]};
      pls_cond_q <= pls_cond;
    end
  end

  // Time base: half-millisecond tick, millisecond every second one
  logic half_tick;
  logic ms_phase_q;
  tick_divider #(
    .CYCLES (HALF_MS_CYCLES)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_q),
    .tick_o  (half_tick)
  );
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ms_phase_q <= 1'b0;
    end else if (half_tick) begin
      ms_phase_q <= ~ms_phase_q;
    end
  end
  wire ms_tick = half_tick & ms_phase_q;

  // Pulse sequencer
  pulse_state_t ps_q;
  pulse_state_t ps_d;
  logic [8:0]   cnt_q;
  logic [8:0]   cnt_d;
  logic         single_ev;
  logic         double_ev;
  // A pulse is short enough while its half-ms count stays within a nonzero limit
  wire          dur_ok   = (pdur_q != 8'h00) && (cnt_q <= {1'b0, pdur_q});
  wire          dur_over = (cnt_q > {1'b0, pdur_q});
  wire          lat_done = (cnt_q >= {1'b0, lat_q});
  wire          win_done = (cnt_q >= {1'b0, win_q});

  always_comb begin
    ps_d      = ps_q;
    cnt_d     = cnt_q;
    single_ev = 1'b0;
    double_ev = 1'b0;
    case (ps_q)
      PS_IDLE: begin
        cnt_d = 9'h0;
        if (pls_cond_q) begin
          ps_d = PS_FIRST;
        end
      end
      PS_FIRST: begin
        if (half_tick) cnt_d = cnt_q + 9'h1;
        if (!pls_cond_q) begin
          single_ev = dur_ok;
          ps_d      = dur_ok ? PS_LATENCY : PS_IDLE;
          cnt_d     = 9'h0;
        end else if (dur_over) begin
          ps_d = PS_WAIT_FALL;
        end
      end
      PS_WAIT_FALL: begin
        if (!pls_cond_q) ps_d = PS_IDLE;
      end
      PS_LATENCY: begin
        // Input ignored here to mask ringing after a tap
        if (ms_tick) cnt_d = cnt_q + 9'h1;
        if (lat_done) begin
          cnt_d = 9'h0;
          ps_d  = (win_q > `WIN_SINGLE) ? PS_WINDOW : PS_IDLE;
        end
      end
      PS_WINDOW: begin
        if (ms_tick) cnt_d = cnt_q + 9'h1;
        if (pls_cond_q) begin
          cnt_d = 9'h0;
          ps_d  = PS_SECOND;
        end else if (win_done) begin
          ps_d = PS_IDLE;
        end
      end
      PS_SECOND: begin
        if (half_tick) cnt_d = cnt_q + 9'h1;
        if (!pls_cond_q) begin
          double_ev = dur_ok;
          ps_d      = PS_IDLE;
        end else if (dur_over) begin
          ps_d = PS_WAIT_FALL;
        end
      end
      default: begin
        ps_d = PS_IDLE;
      end
    endcase
    if (!pulse_on) begin
      ps_d      = PS_IDLE;
      single_ev = 1'b0;
      double_ev = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ps_q  <= PS_IDLE;
      cnt_q <= 9'h0;
    end else begin
      ps_q  <= ps_d;
      cnt_q <= cnt_d;
    end
  end

  // Events, sticky status with write-one-to-clear; set wins
  wire       level_ev = level_on & sample_valid_i & lvl_cond;
  wire [7:0] events   = {5'h0, double_ev, single_ev, level_ev};
  wire [7:0] clr      = (wr_en && hit_stat) ? wdata : 8'h00;
  wire [7:0] status_d = ((status_q & ~clr) | events) & `EV_MASK;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status_q        <= 8'h00;
      irq_o           <= 1'b0;
      level_event_o   <= 1'b0;
      pulse_event_o   <= 1'b0;
      filter_bw_sel_o <= 1'b0;
      drive_strong_o  <= 1'b0;
    end else begin
      status_q        <= status_d;
      irq_o           <= |(status_d & mask_q);
      level_event_o   <= level_ev;
      pulse_event_o   <= single_ev | double_ev;
      filter_bw_sel_o <= ctrl1_q[`C1_BW];
      drive_strong_o  <= ctrl2_q[`C2_DRIVE];
    end
  end

endmodule

// file: motion_params.svh
`ifndef MOTION_PARAMS_SVH
`define MOTION_PARAMS_SVH

// Register indices; byte address is four times the index
`define ADDR_W          10
`define IDX_MODE        8'h16
`define IDX_CTRL1       8'h18
`define IDX_CTRL2       8'h19
`define IDX_LTHR        8'h1a
`define IDX_PTHR        8'h1b
`define IDX_PDUR        8'h1c
`define IDX_LAT         8'h1d
`define IDX_WIN         8'h1e
`define IDX_STATUS      8'h20
`define IDX_MASK        8'h21

// Reset value and writable-bit masks
`define REG_RESET       8'h00
`define MODE_MASK       8'h0f
`define CTRL1_MASK      8'hf8
`define CTRL2_MASK      8'h07
`define EV_MASK         8'h07

// Field positions
`define MODE_LSB        0
`define GLVL_LSB        2
`define C1_BW           7
`define C1_FMT_SEL      6
`define C1_DIS_LSB      3
`define C2_LVL_POL      0
`define C2_PLS_POL      1
`define C2_DRIVE        2
`define EV_LEVEL        0
`define EV_SINGLE       1
`define EV_DOUBLE       2

// Encodings
`define MODE_LEVEL      2'b10
`define MODE_PULSE      2'b11
`define GLVL_8G         2'b00
`define GLVL_2G         2'b01
`define GLVL_4G         2'b10
`define SAT_POS         8'h7f
`define SAT_NEG         8'h80
`define WIN_SINGLE      8'h01

// Timing: 0.5 ms duration step at a 40 ns clock
`define CLK_PERIOD_NS   40
`define PULSE_STEP_NS   500000
`define HALF_MS_CYCLES  (`PULSE_STEP_NS / `CLK_PERIOD_NS)

`endif

// file: motion_pkg.sv
package motion_pkg;

  typedef logic signed [9:0] raw_axis_t;
  typedef logic signed [7:0] out_axis_t;

  // Three axes, index 0 is x
  typedef struct packed {
    raw_axis_t z;
    raw_axis_t y;
    raw_axis_t x;
  } raw_vec_t;

  typedef struct packed {
    out_axis_t z;
    out_axis_t y;
    out_axis_t x;
  } out_vec_t;

  typedef enum logic [2:0] {
    PS_IDLE,
    PS_FIRST,
    PS_WAIT_FALL,
    PS_LATENCY,
    PS_WINDOW,
    PS_SECOND
  } pulse_state_t;

endpackage

// file: sample_source.sv
`timescale 1ns/100ps

// Front-end stand-in: one sample per cycle while go is high
module sample_source
  import motion_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     go_i,
  input  wire raw_vec_t vec_i,
  output raw_vec_t      raw_o,
  output logic          valid_o
);
  initial begin
    raw_o = '0;
    valid_o = 1'b0;
  end
  // Idle data toggles so a stale copy is never mistaken for a sample
  always @(posedge clk_i) begin
    valid_o <= go_i;
    raw_o   <= go_i ? vec_i : ~raw_o;
  end
endmodule

// file: testbench.sv
`timescale 1ns/100ps
`include "motion_params.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  fail_count++; $display("ERROR %s exp %h got %h", n, e, a); end end

module testbench;
  import motion_pkg::*;
  logic       clk_i, resetn_i, rd_s, wr_s, go, wreq, irq, fbw, drv;
  logic       lev, pul, vld;
  logic [9:0] adr;
  logic [31:0] wdat, rdat;
  raw_vec_t   vec, raw;
  out_vec_t   acc;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         lev_n = 0;
  int         pul_n = 0;

  motion_detect_config #(.HALF_MS_CYCLES(4)) u_motion_detect_config (
    .clk_i, .resetn_i, .avs_address_i(adr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .raw_sample_i(raw), .sample_valid_i(vld),
    .accel_o(acc), .filter_bw_sel_o(fbw), .drive_strong_o(drv),
    .level_event_o(lev), .pulse_event_o(pul), .irq_o(irq));
  sample_source u_sample_source (.clk_i, .go_i(go), .vec_i(vec),
    .raw_o(raw), .valid_o(vld));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Event tallies; scenarios compare differences, never reset them
  always @(posedge clk_i) begin
    lev_n <= lev_n + int'(lev);
    pul_n <= pul_n + int'(pul);
  end

  task automatic summarize;
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One Avalon access; held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk_i);
    adr <= {idx, 2'b00};
    wdat <= {24'h0, wd};
    rd_s <= !w;
    wr_s <= w;
    // Sampled at the rising edge; only the watchdog ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (wreq !== 1'b0);
    rd = rdat[7:0];
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] d;
    bus(1'b1, idx, v, d);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] d;
    bus(1'b0, idx, 8'h00, d);
    `CHK("register", e, d)
  endtask
  task automatic feed(input raw_vec_t v, input int n, input int tail);
    @(posedge clk_i);
    go <= 1'b1;
    vec <= v;
    repeat (n) @(posedge clk_i);
    vec <= '0;
    repeat (tail) @(posedge clk_i);
    go <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic lvl(input raw_vec_t v, input int e);
    int b;
    b = lev_n;
    feed(v, 1, 0);
    `CHK("level event", e, lev_n - b)
  endtask

  task automatic t_reset;
    for (int i = 8'h19; i <= 8'h1e; i++) rchk(8'(i), 8'h00);
    wreg(`IDX_CTRL2, 8'hff);
    rchk(`IDX_CTRL2, 8'h07);
    wreg(8'h30, 8'h5a);
    rchk(8'h30, 8'h00);
    for (int i = 8'h1a; i <= 8'h1e; i++) wreg(8'(i), 8'(i + 8'h21));
    for (int i = 8'h1a; i <= 8'h1e; i++) rchk(8'(i), 8'(i + 8'h21));
  endtask
  task automatic t_outs;
    wreg(`IDX_CTRL2, 8'h04);
    wreg(`IDX_CTRL1, 8'h80);
    repeat (3) @(negedge clk_i);
    `CHK("drive", 1'b1, drv)
    `CHK("bandwidth", 1'b1, fbw)
    wreg(`IDX_CTRL2, 8'h00);
    wreg(`IDX_CTRL1, 8'h00);
    repeat (3) @(negedge clk_i);
    `CHK("drive", 1'b0, drv)
    `CHK("bandwidth", 1'b0, fbw)
  endtask
  task automatic t_scale;
    logic [7:0] ex[3] = '{8'h3f, 8'h1f, 8'h0f};
    logic [1:0] gs[3] = '{`GLVL_2G, `GLVL_4G, `GLVL_8G};
    for (int i = 0; i < 3; i++) begin
      wreg(`IDX_MODE, {4'h0, gs[i], 2'b01});
      feed({10'h0, 10'h200, 10'd63}, 1, 0);
      `CHK("accel x", ex[i], acc.x)
      `CHK("accel y", 8'h80, acc.y)
      feed({10'h0, 10'h0, 10'h1ff}, 1, 0);
      `CHK("accel x", 8'h7f, acc.x)
    end
  endtask
  task automatic t_level;
    wreg(`IDX_MODE, 8'h06);
    wreg(`IDX_LTHR, 8'h20);
    lvl({10'h0, 10'h0, 10'h30}, 1);
    lvl({10'h0, 10'h0, 10'h10}, 0);
    wreg(`IDX_CTRL2, 8'h01);
    lvl(30'h0, 1);
    lvl({10'h0, 10'h30, 10'h0}, 0);
    wreg(`IDX_MODE, 8'h07);
    lvl(30'h0, 0);
  endtask
  task automatic t_format;
    wreg(`IDX_MODE, 8'h06);
    wreg(`IDX_CTRL2, 8'h00);
    wreg(`IDX_CTRL1, 8'h30);
    wreg(`IDX_LTHR, 8'ha0);
    wreg(`IDX_STATUS, 8'h07);
    lvl({10'h0, 10'h0, -10'sd112}, 1);
    `CHK("irq masked", 1'b0, irq)
    wreg(`IDX_MASK, 8'h01);
    repeat (2) @(negedge clk_i);
    `CHK("irq raised", 1'b1, irq)
    wreg(`IDX_STATUS, 8'h01);
    repeat (2) @(negedge clk_i);
    `CHK("irq cleared", 1'b0, irq)
    wreg(`IDX_CTRL1, 8'h70);
    lvl({10'h0, 10'h0, -10'sd112}, 0);
  endtask
  task automatic t_pulse;
    int b;
    wreg(`IDX_CTRL1, 8'h00);
    wreg(`IDX_PTHR, 8'h10);
    wreg(`IDX_PDUR, 8'h04);
    wreg(`IDX_LAT, 8'h00);
    wreg(`IDX_WIN, `WIN_SINGLE);
    wreg(`IDX_MODE, 8'h07);
    b = pul_n;
    feed({20'h0, 10'h40}, 6, 40);
    `CHK("short pulse", 1, pul_n - b)
    b = pul_n;
    feed({20'h0, 10'h40}, 40, 40);
    `CHK("long pulse", 0, pul_n - b)
  endtask

  // Two taps: window gives a double, long latency hides the second
  task automatic t_window;
    int b;
    wreg(`IDX_CTRL1, 8'h40);
    wreg(`IDX_LAT, 8'h01);
    wreg(`IDX_WIN, 8'h0a);
    wreg(`IDX_STATUS, 8'h07);
    b = pul_n;
    feed({20'h0, -10'sd64}, 6, 20);
    feed({20'h0, -10'sd64}, 6, 20);
    `CHK("double pulse", 2, pul_n - b)
    rchk(`IDX_STATUS, 8'h06);
    wreg(`IDX_LAT, 8'h0a);
    b = pul_n;
    feed({20'h0, -10'sd64}, 6, 20);
    feed({20'h0, -10'sd64}, 6, 20);
    `CHK("latency pulse", 1, pul_n - b)
  endtask

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    summarize;
  end
  initial begin
    resetn_i = 1'b0;
    rd_s = 1'b0;
    wr_s = 1'b0;
    go = 1'b0;
    adr = '0;
    wdat = '0;
    vec = '0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset;
    t_outs;
    t_scale;
    t_level;
    t_format;
    t_pulse;
    t_window;
    summarize;
  end
endmodule

// file: tick_divider.sv
`timescale 1ns/100ps

// Free-running divider giving a one-cycle tick every CYCLES clocks
module tick_divider #(
  parameter int unsigned CYCLES = 12500
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);

  logic [31:0] cnt_q;
  wire         wrap = (cnt_q == 32'(CYCLES - 1));

  // Counter and registered tick
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 32'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= wrap ? 32'h0 : cnt_q + 32'h1;
      tick_o <= wrap;
    end
  end

endmodule
